// [core/mcss_pkg.sv]
// Package: register map and state encoding of the current scale sequencer
package mcss_pkg;
   // ---------------------------------------------------------------
   // Register offsets (word addresses on the register port)
   // ---------------------------------------------------------------
   localparam int ADDR_W = 7;
   localparam logic [6:0] OFS_STANDBY_ENTRY_DELAY = 7'h15;
   localparam logic [6:0] OFS_COAST_ENTRY_DELAY = 7'h16;
   localparam logic [6:0] OFS_DRIVE_LEVEL_VEL_THR = 7'h17;
   localparam logic [6:0] OFS_RISE_STEP_INTERVAL = 7'h18;
   localparam logic [6:0] OFS_HOLD_FALL_INTERVAL = 7'h19;
   localparam logic [6:0] OFS_DRIVE_FALL_INTERVAL = 7'h1A;
   localparam logic [6:0] OFS_BOOST_DURATION = 7'h1B;
   localparam logic [6:0] OFS_SCALE_READBACK = 7'h7C;
   // ---------------------------------------------------------------
   // Field widths and reset values
   // ---------------------------------------------------------------
   localparam int DLY_W = 32;
   localparam int IVL_W = 24;
   localparam int VEL_W = 24;
   localparam int LVL_W = 8;
   localparam int SCALE_W = 9;
   localparam logic [31:0] RST_DELAY32 = 32'h00000000;
   localparam logic [23:0] RST_DELAY24 = 24'h000000;
   localparam logic [8:0] RST_SCALE = 9'h000;
   localparam logic [31:0] RST_CIRC_DEC = 32'h00000000;
   // ---------------------------------------------------------------
   // Current phase of the motor
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      PH_MOVING,
      PH_STOP_WAIT,
      PH_STANDBY,
      PH_COAST
   } mcss_phase_e;
endpackage

// [core/mcss_sequencer.sv]
// Current scale sequencer: standby/coast timing, level choice and ramping
// Functional notes
// [R01] After ramp stop, wait standby entry delay cycles before standby.
// [R02] After standby starts, wait coast entry delay cycles before coasting.
// [R03] Without voltage PWM, above threshold velocity use second drive level.
// [R04] With voltage PWM, threshold register serves as full amplitude velocity.
// [R05] Raise scale one step per rise interval toward higher target.
// [R06] Lower scale one step per hold fall interval toward hold level.
// [R07] Lower scale one step per drive fall interval toward lower drive level.
// [R08] Boost stays active for boost duration cycles after ramp start.
// [R09] Readback address returns scale in use, 9 bits, reset zero.
// [R10] Writes to readback address load circular decimal step instead.
// [R11] Velocity level selection only when second drive level is enabled.
// [R12] Coasting after standby only when coast enable is set.
// [R13] Zero delays or intervals act without extra waiting cycles.
`timescale 1ns/10ps
module mcss_sequencer
   import mcss_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic reg_wr_en,
   input wire logic [mcss_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata_r,
   input wire logic ramp_running,
   input wire logic [mcss_pkg::VEL_W-1:0] actual_velocity,
   input wire logic voltage_pwm_en,
   input wire logic second_drive_en,
   input wire logic coast_en,
   input wire logic [mcss_pkg::LVL_W-1:0] boost_current_level,
   input wire logic [mcss_pkg::LVL_W-1:0] first_drive_current_level,
   input wire logic [mcss_pkg::LVL_W-1:0] second_drive_current_level,
   input wire logic [mcss_pkg::LVL_W-1:0] hold_current_level,
   output logic [mcss_pkg::SCALE_W-1:0] current_scale_r,
   output logic standby_active_r,
   output logic coast_active_r,
   output logic boost_active_r,
   output logic [mcss_pkg::VEL_W-1:0] pwm_full_amplitude_velocity_r,
   output logic [31:0] circular_decimal_step_r
);
   import mcss_pkg::*;

   logic [DLY_W-1:0] standby_entry_delay_r;
   logic [DLY_W-1:0] coast_entry_delay_r;
   logic [VEL_W-1:0] drive_level_velocity_threshold_r;
   logic [IVL_W-1:0] current_rise_step_interval_r;
   logic [IVL_W-1:0] hold_fall_step_interval_r;
   logic [IVL_W-1:0] drive_fall_step_interval_r;
   logic [DLY_W-1:0] boost_duration_r;
   mcss_phase_e phase_r;
   mcss_phase_e phase_nxt;
   logic [DLY_W-1:0] wait_cnt_r;
   logic [DLY_W-1:0] boost_cnt_r;
   logic [IVL_W-1:0] step_cnt_r;
   logic ramp_running_d_r;

   // ---------------------------------------------------------------
   // Register decode
   // ---------------------------------------------------------------
   wire wr_stby = reg_wr_en && (reg_addr == OFS_STANDBY_ENTRY_DELAY);
   wire wr_coast = reg_wr_en && (reg_addr == OFS_COAST_ENTRY_DELAY);
   wire wr_thr = reg_wr_en && (reg_addr == OFS_DRIVE_LEVEL_VEL_THR);
   wire wr_rise = reg_wr_en && (reg_addr == OFS_RISE_STEP_INTERVAL);
   wire wr_hfall = reg_wr_en && (reg_addr == OFS_HOLD_FALL_INTERVAL);
   wire wr_dfall = reg_wr_en && (reg_addr == OFS_DRIVE_FALL_INTERVAL);
   wire wr_boost = reg_wr_en && (reg_addr == OFS_BOOST_DURATION);
   wire wr_circ = reg_wr_en && (reg_addr == OFS_SCALE_READBACK);

   // Read mux; unmapped addresses answer zero
   logic [31:0] rd_mux;
   always_comb
   begin
      case (reg_addr)
         OFS_STANDBY_ENTRY_DELAY: rd_mux = standby_entry_delay_r;
         OFS_COAST_ENTRY_DELAY: rd_mux = coast_entry_delay_r;
         OFS_DRIVE_LEVEL_VEL_THR: rd_mux = {8'h00, drive_level_velocity_threshold_r};
         OFS_RISE_STEP_INTERVAL: rd_mux = {8'h00, current_rise_step_interval_r};
         OFS_HOLD_FALL_INTERVAL: rd_mux = {8'h00, hold_fall_step_interval_r};
         OFS_DRIVE_FALL_INTERVAL: rd_mux = {8'h00, drive_fall_step_interval_r};
         OFS_BOOST_DURATION: rd_mux = boost_duration_r;
         // [R09] scale readback
         OFS_SCALE_READBACK: rd_mux = {23'h000000, current_scale_r};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // Register storage; the readback address is write-only for the step
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         standby_entry_delay_r <= RST_DELAY32;
         coast_entry_delay_r <= RST_DELAY32;
         drive_level_velocity_threshold_r <= RST_DELAY24;
         current_rise_step_interval_r <= RST_DELAY24;
         hold_fall_step_interval_r <= RST_DELAY24;
         drive_fall_step_interval_r <= RST_DELAY24;
         boost_duration_r <= RST_DELAY32;
         circular_decimal_step_r <= RST_CIRC_DEC;
         reg_rdata_r <= 32'h00000000;
      end
      else
      begin
         if (wr_stby) standby_entry_delay_r <= reg_wdata;
         if (wr_coast) coast_entry_delay_r <= reg_wdata;
         if (wr_thr) drive_level_velocity_threshold_r <= reg_wdata[23:0];
         if (wr_rise) current_rise_step_interval_r <= reg_wdata[23:0];
         if (wr_hfall) hold_fall_step_interval_r <= reg_wdata[23:0];
         if (wr_dfall) drive_fall_step_interval_r <= reg_wdata[23:0];
         if (wr_boost) boost_duration_r <= reg_wdata;
         // [R10] write loads step
         if (wr_circ) circular_decimal_step_r <= reg_wdata;
         reg_rdata_r <= rd_mux;
      end
   end

   // ---------------------------------------------------------------
   // Phase sequencing: moving, stop wait, standby, coast
   // ---------------------------------------------------------------
   wire stby_due = (wait_cnt_r >= standby_entry_delay_r);
   wire coast_due = (wait_cnt_r >= coast_entry_delay_r);
   wire ramp_start = ramp_running && !ramp_running_d_r;

   always_comb
   begin
      phase_nxt = phase_r;
      case (phase_r)
         PH_MOVING:
            if (!ramp_running) phase_nxt = PH_STOP_WAIT;
         // [R01] standby delay, [R13] zero means next cycle
         PH_STOP_WAIT:
            if (ramp_running) phase_nxt = PH_MOVING;
            else if (stby_due) phase_nxt = PH_STANDBY;
         // [R02] [R12] coast only when enabled
         PH_STANDBY:
            if (ramp_running) phase_nxt = PH_MOVING;
            else if (coast_en && coast_due) phase_nxt = PH_COAST;
         PH_COAST:
            if (ramp_running) phase_nxt = PH_MOVING;
         default: phase_nxt = PH_MOVING;
      endcase
   end

   // Wait counter restarts on each phase change so both delays count fresh
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         phase_r <= PH_STOP_WAIT;
         wait_cnt_r <= RST_DELAY32;
         ramp_running_d_r <= 1'b0;
         standby_active_r <= 1'b0;
         coast_active_r <= 1'b0;
      end
      else
      begin
         phase_r <= phase_nxt;
         wait_cnt_r <= (phase_nxt != phase_r) ? RST_DELAY32 : wait_cnt_r + 32'h1;
         ramp_running_d_r <= ramp_running;
         standby_active_r <= (phase_nxt == PH_STANDBY);
         coast_active_r <= (phase_nxt == PH_COAST);
      end
   end

   // ---------------------------------------------------------------
   // Boost window after ramp start
   // ---------------------------------------------------------------
   // [R08] boost window length
   wire boost_nxt = ramp_start ? (boost_duration_r != RST_DELAY32)
                  : (boost_active_r && ramp_running
                     && (boost_cnt_r + 32'h1 < boost_duration_r));
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         boost_active_r <= 1'b0;
         boost_cnt_r <= RST_DELAY32;
      end
      else
      begin
         boost_active_r <= boost_nxt;
         boost_cnt_r <= ramp_start ? RST_DELAY32 : boost_cnt_r + 32'h1;
      end
   end

   // ---------------------------------------------------------------
   // Target level and step ramping
   // ---------------------------------------------------------------
   // [R03] [R11] velocity picks drive level
   wire use_second = second_drive_en && !voltage_pwm_en
                   && (actual_velocity > drive_level_velocity_threshold_r);
   wire [LVL_W-1:0] drive_level = use_second ? second_drive_current_level
                                             : first_drive_current_level;
   wire at_rest = (phase_r == PH_STANDBY) || (phase_r == PH_COAST);
   wire [SCALE_W-1:0] target = (phase_r == PH_COAST) ? RST_SCALE
                      : at_rest ? {1'b0, hold_current_level}
                      : boost_active_r ? {1'b0, boost_current_level}
                      : {1'b0, drive_level};
   wire go_up = target > current_scale_r;
   wire go_down = target < current_scale_r;
   // [R05] [R06] [R07] interval per direction
   wire [IVL_W-1:0] interval = go_up ? current_rise_step_interval_r
                             : at_rest ? hold_fall_step_interval_r
                             : drive_fall_step_interval_r;
   wire step_due = (step_cnt_r >= interval);

   // Coast drops the scale at once: freewheeling means no current at all
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         current_scale_r <= RST_SCALE;
         step_cnt_r <= RST_DELAY24;
      end
      else if (phase_r == PH_COAST)
      begin
         current_scale_r <= RST_SCALE;
         step_cnt_r <= RST_DELAY24;
      end
      else if ((go_up || go_down) && step_due)
      begin
         current_scale_r <= go_up ? current_scale_r + 9'h001
                                  : current_scale_r - 9'h001;
         step_cnt_r <= RST_DELAY24;
      end
      else
      begin
         current_scale_r <= current_scale_r;
         step_cnt_r <= (go_up || go_down) ? step_cnt_r + 24'h000001
                                          : RST_DELAY24;
      end
   end

   // [R04] threshold as full amplitude velocity
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         pwm_full_amplitude_velocity_r <= RST_DELAY24;
      else
         pwm_full_amplitude_velocity_r <= voltage_pwm_en
            ? drive_level_velocity_threshold_r : RST_DELAY24;
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   AST_STANDBY_ENTRY: assert property ( // [R01]
      (phase_r == PH_STOP_WAIT && !ramp_running && stby_due)
      |=> standby_active_r)
      else $error("standby not entered after delay");
   AST_STANDBY_EARLY: assert property ( // [R01]
      (phase_r == PH_STOP_WAIT && !stby_due) |=> !standby_active_r)
      else $error("standby entered before delay");
   AST_COAST_ENTRY: assert property ( // [R02]
      (phase_r == PH_STANDBY && !ramp_running && coast_en && coast_due)
      |=> coast_active_r ##1 (current_scale_r == 9'h000))
      else $error("coast not entered after delay");
   AST_COAST_BLOCKED: assert property ( // [R12]
      (phase_r == PH_STANDBY && !coast_en && !ramp_running)
      |=> !coast_active_r)
      else $error("coast without enable");
   AST_LEVEL_SELECT: assert property ( // [R11]
      (!at_rest && !boost_active_r && !second_drive_en)
      |-> target == {1'b0, first_drive_current_level})
      else $error("wrong drive level");
   AST_RISE_STEP: assert property ( // [R05]
      (phase_r != PH_COAST && go_up && step_due)
      |=> current_scale_r == $past(current_scale_r) + 9'h001)
      else $error("scale did not rise");
   AST_FALL_STEP: assert property ( // [R07]
      (phase_r != PH_COAST && go_down && !step_due)
      |=> current_scale_r == $past(current_scale_r))
      else $error("scale fell early");
   AST_BOOST_LEN: assert property ( // [R08]
      boost_active_r |-> (boost_cnt_r < boost_duration_r))
      else $error("boost too long");
   AST_READBACK: assert property ( // [R09]
      (reg_addr == OFS_SCALE_READBACK)
      |=> reg_rdata_r == {23'h000000, $past(current_scale_r)})
      else $error("bad scale readback");
   AST_CIRC_WRITE: assert property ( // [R10]
      wr_circ |=> circular_decimal_step_r == $past(reg_wdata))
      else $error("step not loaded");
   AST_PWM_VEL: assert property ( // [R04]
      voltage_pwm_en |=> pwm_full_amplitude_velocity_r
                         == $past(drive_level_velocity_threshold_r))
      else $error("pwm velocity mismatch");
endmodule

// [verification/mcss_drive_model.sv]
// Stepper driver model: takes each scale value and flags illegal jumps
`timescale 1ns/10ps
module mcss_drive_model
   import mcss_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [mcss_pkg::SCALE_W-1:0] current_scale,
   input wire logic coast_active,
   output logic jump_seen_r
);
   logic [mcss_pkg::SCALE_W-1:0] last_scale_r;
   logic last_coast_r;
   logic step_bad;
   // A winding must see single steps; only coasting may cut it at once
   assign step_bad = !coast_active && !last_coast_r
      && (current_scale != last_scale_r)
      && (current_scale != last_scale_r + 9'h001)
      && (current_scale != last_scale_r - 9'h001);
   // Remember the last value and latch any jump until reset
   always_ff @(posedge ref_clk)
   begin
      last_scale_r <= current_scale;
      last_coast_r <= coast_active;
      if (reset)
         jump_seen_r <= 1'b0;
      else if (step_bad)
         jump_seen_r <= 1'b1;
   end
endmodule

// [verification/motor_current_scale_sequencer_tb.sv]
// Testbench: register access and scale sequencing of the sequencer
`timescale 1ns/10ps
module motor_current_scale_sequencer_tb;
   import mcss_pkg::*;
`define CHK(a, e, m) begin checks++; if ((a) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %0t %s", $time, m); end end
   logic ref_clk, reset, reg_wr_en, ramp_running, voltage_pwm_en;
   logic second_drive_en, coast_en, standby_active_r, coast_active_r;
   logic boost_active_r, jump_seen;
   logic [6:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata_r, circular_decimal_step_r;
   logic [23:0] actual_velocity, pwm_full_amplitude_velocity_r;
   logic [7:0] lvl_boost, lvl_first, lvl_second, lvl_hold;
   logic [8:0] current_scale_r;
   logic [6:0] addrs [7] = '{OFS_STANDBY_ENTRY_DELAY, OFS_COAST_ENTRY_DELAY,
      OFS_DRIVE_LEVEL_VEL_THR, OFS_RISE_STEP_INTERVAL, OFS_HOLD_FALL_INTERVAL,
      OFS_DRIVE_FALL_INTERVAL, OFS_BOOST_DURATION};
   int error_cnt = 0, checks = 0, cyc = 0, n, i;
   mcss_sequencer i_dut (.ref_clk(ref_clk), .reset(reset),
      .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata_r(reg_rdata_r), .ramp_running(ramp_running),
      .actual_velocity(actual_velocity), .voltage_pwm_en(voltage_pwm_en),
      .second_drive_en(second_drive_en), .coast_en(coast_en),
      .boost_current_level(lvl_boost), .first_drive_current_level(lvl_first),
      .second_drive_current_level(lvl_second),
      .hold_current_level(lvl_hold), .current_scale_r(current_scale_r),
      .standby_active_r(standby_active_r), .coast_active_r(coast_active_r),
      .boost_active_r(boost_active_r),
      .pwm_full_amplitude_velocity_r(pwm_full_amplitude_velocity_r),
      .circular_decimal_step_r(circular_decimal_step_r));
   mcss_drive_model i_drv (.ref_clk(ref_clk), .reset(reset),
      .current_scale(current_scale_r), .coast_active(coast_active_r),
      .jump_seen_r(jump_seen));
   // ---------------------------------------------------------------
   // Clock, timeout and bus tasks
   // ---------------------------------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // Whole run needs about 850 cycles; a hang is cut well above that
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         error_cnt++;
         finish_test();
      end
   end
   task automatic finish_test();
      if (error_cnt == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      @(negedge ref_clk);
      reg_wr_en = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge ref_clk);
      reg_wr_en = 1'b0;
   endtask
   // Read data is registered, so it settles one edge after the address
   task automatic rd(input logic [6:0] a, input logic [31:0] e);
      @(negedge ref_clk);
      reg_addr = a;
      @(negedge ref_clk);
      `CHK(reg_rdata_r, e, "read data")
   endtask
   task automatic wait_scale(input logic [8:0] t, input int lo, input int hi);
      n = 0;
      while (current_scale_r !== t && n < 2000)
      begin
         @(negedge ref_clk);
         n++;
      end
      `CHK(n >= lo && n <= hi, 1'b1, "scale step timing")
   endtask
   function automatic logic flag(input int w);
      return w == 0 ? standby_active_r : w == 1 ? coast_active_r
         : boost_active_r;
   endfunction
   // Counts falling edges until the chosen standby, coast or boost flag is seen high
   task automatic wait_hi(input int w);
      n = 0;
      while (flag(w) !== 1'b1 && n < 100)
      begin
         @(negedge ref_clk);
         n++;
      end
   endtask
   task automatic set_ramp(input logic run);
      @(negedge ref_clk);
      ramp_running = run;
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      {reset, reg_wr_en, ramp_running, voltage_pwm_en, coast_en} = 5'h10;
      {reg_addr, reg_wdata, actual_velocity} = '0;
      {lvl_boost, lvl_first, lvl_second, lvl_hold} = 32'h20204000;
      second_drive_en = 1'b1;
      repeat (16) @(negedge ref_clk);
      reset = 1'b0;
      for (i = 0; i < 7; i++)
         rd(addrs[i], 32'h00000000);
      rd(OFS_SCALE_READBACK, 32'h00000000);
      for (i = 0; i < 7; i++)
      begin
         wr(addrs[i], 32'hFFFFFFFF);
         rd(addrs[i],
            (i > 1 && i < 6) ? 32'h00FFFFFF : 32'hFFFFFFFF);
      end
      wr(OFS_SCALE_READBACK, 32'h1234ABCD);
      `CHK(circular_decimal_step_r, 32'h1234ABCD, "step load")
      rd(OFS_SCALE_READBACK, 32'h00000000);
      wr(7'h20, 32'h00000055);
      rd(7'h20, 32'h00000000);
      for (i = 0; i < 7; i++)
         wr(addrs[i], i == 3 ? 32'h0 : (i == 2 ? 32'h100 : 32'h5 + i * 3));
      wr(OFS_RISE_STEP_INTERVAL, 32'h0);
      wr(OFS_HOLD_FALL_INTERVAL, 32'hC);
      wr(OFS_DRIVE_FALL_INTERVAL, 32'h6);
      wr(OFS_BOOST_DURATION, 32'hA);
      actual_velocity = 24'h000080;
      set_ramp(1'b1);
      wait_scale(9'h020, 32, 40);
      wr(OFS_RISE_STEP_INTERVAL, 32'h2);
      actual_velocity = 24'h000101;
      wait_scale(9'h040, 64, 132);
      rd(OFS_SCALE_READBACK, 32'h00000040);
      actual_velocity = 24'h000100;
      wait_scale(9'h020, 192, 260);
      second_drive_en = 1'b0;
      actual_velocity = 24'h000200;
      repeat (40) @(negedge ref_clk);
      `CHK(current_scale_r, 9'h020, "single drive level")
      voltage_pwm_en = 1'b1;
      repeat (2) @(negedge ref_clk);
      `CHK(pwm_full_amplitude_velocity_r, 24'h000100, "pwm velocity")
      voltage_pwm_en = 1'b0;
      repeat (2) @(negedge ref_clk);
      `CHK(pwm_full_amplitude_velocity_r, 24'h000000, "pwm off")
      set_ramp(1'b0);
      // Stop seen at edge 1, delay of 5 counted, standby shows at edge 7
      wait_hi(0);
      `CHK(n, 7, "standby delay")
      wait_scale(9'h010, 192, 228);
      repeat (100) @(negedge ref_clk);
      `CHK(coast_active_r, 1'b0, "coast disabled")
      set_ramp(1'b1);
      wait_hi(2);
      n = 0;
      while (boost_active_r === 1'b1 && n < 50)
      begin
         @(negedge ref_clk);
         n++;
      end
      `CHK(n, 10, "boost window")
      coast_en = 1'b1;
      set_ramp(1'b0);
      wait_hi(0);
      `CHK(n, 7, "standby delay again")
      // Coast delay of 8 counts from the edge after standby starts
      wait_hi(1);
      `CHK(n, 9, "coast delay")
      @(negedge ref_clk);
      `CHK(current_scale_r, 9'h000, "coast scale")
      `CHK(jump_seen, 1'b0, "single steps")
      finish_test();
   end
endmodule
